// >>> verilog/io_command_unit.sv
// Purpose: executes the 16-bit command field of the io command instruction
// Assumes: core presents one command at a time and holds it until taken
// Notes: all outputs are registered; interrupt n is held at bit 15-n
//
// Summary of operation
// - 2000 writes the source word into the interrupt mask; 1 lets interrupt through.
// - 2001 clears all pending interrupts and the fault register.
// - 2002 enables unmasked interrupts after the next instruction completes.
// - 2003 disables disableable interrupts at once; non-disableable ones stay active.
// - 2004 clears one pending bit chosen by low nibble; interrupt 1 also clears faults.
// - 2005 ors source into pending; masked-in enabled bits then request service.
// - 200E copies the source word into the status word.
// - A000, A004, A00E return mask, pending and status; source untouched.
// - A00F returns the fault register, then clears it and pending interrupt 1.
// - 4003 hands write protection over to the protect memory.
// - 4006 enables direct memory access, 4007 disables it.
// - 4008 runs timer A in 10 us steps, 4009 holds it.
// - 400A loads timer A from source and starts it; lsb is 10 us.
// - 400C runs timer B in 100 us steps, 400D holds it.
// - 400E loads timer B from source and starts it counting.
// - C00E returns timer B; lsb is 100 us.
// - 400B raises the go output and restarts its timeout; it drops on expiry.
// - 50XX writes the source word into protect memory word XX for XX up to 7F; a higher XX is illegal.
// - each protect bit guards one 1024-word block; words 64-127 guard direct access.
// - D0XX returns protect memory word XX for XX up to 7F; a higher XX is illegal.
// - D1XY and D2XY return instruction or operand page register Y of group X.
// - 4000 sends source to the terminal high byte first; no terminal means no-op.
// - C00A returns timer A; lsb is 10 us.
`timescale 1ns/10ps
`include "io_cmd_cfg.svh"
module io_command_unit
    import io_cmd_pkg::*;
#(
    parameter int GO_CYCLES = `GO_TIMEOUT_CYC,
    parameter logic [15:0] UNMASKABLE = `UNMASKABLE_DEFAULT,
    parameter logic [15:0] UNDISABLEABLE = `UNDISABLEABLE_DEFAULT
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire cmd_req_t cmd_in,
    input wire logic instr_done_in,
    input wire logic [15:0] irq_in,
    input wire logic [15:0] fault_in,
    input wire logic terminal_present_in,
    input wire logic terminal_ready_in,
    input wire logic [9:0] protect_addr_in,
    input wire logic protect_dma_in,
    output logic cmd_ready_out,
    output cmd_resp_t resp_out,
    output term_byte_t terminal_out,
    output logic int_request_out,
    output logic [15:0] pending_out,
    output logic [15:0] status_word_out,
    output logic int_enabled_out,
    output logic dma_enable_out,
    output logic protect_active_out,
    output logic write_protect_out,
    output logic go_out
);
    localparam int GO_W = $clog2(GO_CYCLES + 1);
    localparam int PRE_A_W = $clog2(`TIMER_A_STEP_CYC + 1);

    function automatic logic [15:0] bit_of(input logic [3:0] num);
        bit_of = 16'h8000 >> num;
    endfunction : bit_of

    unit_state_t state_reg;
    logic [15:0] interrupt_mask;
    logic [15:0] pending_interrupts;
    logic [15:0] fault_flags;
    logic [15:0] status_reg;
    logic enable_reg;
    logic enable_armed_reg;
    logic [15:0] fast_timer_count;
    logic [15:0] slow_timer_count;
    logic timer_a_run_reg;
    logic timer_b_run_reg;
    logic [PRE_A_W-1:0] pre_a_reg;
    logic [3:0] pre_b_reg;
    logic tick_a;
    logic tick_b;
    logic [GO_W-1:0] go_count_reg;
    logic [15:0] protect_ram [0:`PROTECT_WORDS-1];
    logic [15:0] instr_page [0:255];
    logic [15:0] oper_page [0:255];
    logic [15:0] term_word_reg;

    logic take;
    logic [15:0] code;
    logic [15:0] src;
    logic [7:0] code_hi;
    logic [7:0] code_lo;
    logic legal;
    logic [15:0] rd_data;
    logic rd_valid;
    logic protect_cmd_ok;

    assign take = cmd_in.valid && cmd_ready_out;
    assign code = cmd_in.code;
    assign src = cmd_in.src;
    assign code_hi = code[15:8];
    assign code_lo = code[7:0];
    // only 128 protect words exist; a higher index is no command at all
    assign protect_cmd_ok = (code_lo[7] == 1'b0);

    // decode: which commands exist and what a read returns
    always_comb
    begin
        legal = 1'b1;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
        case (code)
            `CMD_MASK_WRITE, `CMD_CLEAR_ALL, `CMD_INT_ENABLE, `CMD_INT_DISABLE,
            `CMD_PENDING_RESET, `CMD_PENDING_SET, `CMD_STATUS_WRITE,
            `CMD_TERMINAL_OUT, `CMD_PROTECT_ACTIVATE, `CMD_DMA_ENABLE,
            `CMD_DMA_DISABLE, `CMD_TIMER_A_START, `CMD_TIMER_A_HALT,
            `CMD_TIMER_A_LOAD, `CMD_GO, `CMD_TIMER_B_START, `CMD_TIMER_B_HALT,
            `CMD_TIMER_B_LOAD:
                legal = 1'b1;
            `CMD_MASK_READ:
            begin
                rd_valid = 1'b1;
                rd_data = interrupt_mask;
            end
            `CMD_PENDING_READ:
            begin
                rd_valid = 1'b1;
                rd_data = pending_interrupts;
            end
            `CMD_STATUS_READ:
            begin
                rd_valid = 1'b1;
                rd_data = status_reg;
            end
            `CMD_FAULT_READ_CLEAR:
            begin
                rd_valid = 1'b1;
                rd_data = fault_flags;
            end
            `CMD_TIMER_A_READ:
            begin
                rd_valid = 1'b1;
                rd_data = fast_timer_count;
            end
            `CMD_TIMER_B_READ:
            begin
                rd_valid = 1'b1;
                rd_data = slow_timer_count;
            end
            default:
            begin
                case (code_hi)
                    `CMD_HI_PROTECT_WRITE:
                        legal = protect_cmd_ok;
                    `CMD_HI_INSTR_PAGE_WRITE, `CMD_HI_OPER_PAGE_WRITE:
                        legal = 1'b1;
                    `CMD_HI_PROTECT_READ:
                    begin
                        legal = protect_cmd_ok;
                        rd_valid = protect_cmd_ok;
                        rd_data = protect_ram[code_lo[6:0]];
                    end
                    `CMD_HI_INSTR_PAGE_READ:
                    begin
                        rd_valid = 1'b1;
                        rd_data = instr_page[code_lo];
                    end
                    `CMD_HI_OPER_PAGE_READ:
                    begin
                        rd_valid = 1'b1;
                        rd_data = oper_page[code_lo];
                    end
                    default:
                        legal = 1'b0;
                endcase
            end
        endcase
    end

    // command sequencing and the answer to the core
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_IDLE;
            cmd_ready_out <= 1'b1;
            resp_out <= '0;
            terminal_out <= '0;
            term_word_reg <= 16'h0000;
        end
        else
        begin
            resp_out.done <= 1'b0;
            resp_out.write <= 1'b0;
            resp_out.illegal <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (take && code == `CMD_TERMINAL_OUT && terminal_present_in)
                    begin
                        // the command completes only when both bytes are gone
                        state_reg <= ST_TERM_HI;
                        cmd_ready_out <= 1'b0;
                        term_word_reg <= src;
                        terminal_out.valid <= 1'b1;
                        terminal_out.data <= src[15:8];
                    end
                    else if (take)
                    begin
                        resp_out.done <= 1'b1;
                        resp_out.write <= rd_valid;
                        resp_out.illegal <= ~legal;
                        resp_out.data <= rd_valid ? rd_data : 16'h0000;
                    end
                end
                ST_TERM_HI:
                begin
                    if (terminal_ready_in)
                    begin
                        state_reg <= ST_TERM_LO;
                        terminal_out.data <= term_word_reg[7:0];
                    end
                end
                ST_TERM_LO:
                begin
                    if (terminal_ready_in)
                    begin
                        state_reg <= ST_IDLE;
                        cmd_ready_out <= 1'b1;
                        terminal_out.valid <= 1'b0;
                        resp_out.done <= 1'b1;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                    cmd_ready_out <= 1'b1;
                    terminal_out.valid <= 1'b0;
                end
            endcase
        end
    end

    // mask and status word
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            interrupt_mask <= 16'h0000;
            status_reg <= 16'h0000;
        end
        else if (take)
        begin
            if (code == `CMD_MASK_WRITE)
                interrupt_mask <= src;
            if (code == `CMD_STATUS_WRITE)
                status_reg <= src;
        end
    end

    // pending and fault: clears are applied first so a same-cycle event survives
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pending_interrupts <= 16'h0000;
            fault_flags <= 16'h0000;
        end
        else
        begin
            logic [15:0] pend_n;
            logic [15:0] fault_n;
            pend_n = pending_interrupts;
            fault_n = fault_flags;
            if (take && state_reg == ST_IDLE)
            begin
                case (code)
                    `CMD_CLEAR_ALL:
                    begin
                        pend_n = 16'h0000;
                        fault_n = 16'h0000;
                    end
                    `CMD_PENDING_RESET:
                    begin
                        pend_n = pend_n & ~bit_of(src[3:0]);
                        if (src[3:0] == 4'h1)
                            fault_n = 16'h0000;
                    end
                    `CMD_PENDING_SET:
                        pend_n = pend_n | src;
                    `CMD_FAULT_READ_CLEAR:
                    begin
                        fault_n = 16'h0000;
                        pend_n[`PENDING_FAULT_BIT] = 1'b0;
                    end
                    default:
                        fault_n[`FAULT_ILLEGAL_IO_BIT] = fault_n[`FAULT_ILLEGAL_IO_BIT] | ~legal;
                endcase
            end
            fault_n = fault_n | fault_in;
            pend_n = pend_n | irq_in;
            if (fault_n != 16'h0000)
                pend_n[`PENDING_FAULT_BIT] = 1'b1;
            pending_interrupts <= pend_n;
            fault_flags <= fault_n;
        end
    end

    // interrupt enable with its one-instruction delay
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            enable_reg <= 1'b0;
            enable_armed_reg <= 1'b0;
        end
        else if (take && code == `CMD_INT_DISABLE)
        begin
            enable_reg <= 1'b0;
            enable_armed_reg <= 1'b0;
        end
        else if (take && code == `CMD_INT_ENABLE)
            enable_armed_reg <= 1'b1;
        else if (enable_armed_reg && instr_done_in)
        begin
            enable_reg <= 1'b1;
            enable_armed_reg <= 1'b0;
        end
    end

    // request level; the core takes it after its current instruction
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            int_request_out <= 1'b0;
            pending_out <= 16'h0000;
            status_word_out <= 16'h0000;
            int_enabled_out <= 1'b0;
        end
        else
        begin
            int_request_out <= |(pending_interrupts & (interrupt_mask | UNMASKABLE) &
                ({16{enable_reg}} | UNDISABLEABLE));
            pending_out <= pending_interrupts;
            status_word_out <= status_reg;
            int_enabled_out <= enable_reg;
        end
    end

    // dma and protect controls
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            dma_enable_out <= 1'b0;
            protect_active_out <= 1'b0;
        end
        else if (take)
        begin
            if (code == `CMD_DMA_ENABLE)
                dma_enable_out <= 1'b1;
            if (code == `CMD_DMA_DISABLE)
                dma_enable_out <= 1'b0;
            if (code == `CMD_PROTECT_ACTIVATE)
                protect_active_out <= 1'b1;
        end
    end

    // protect memory and page registers; no reset, software loads them first
    always_ff @(posedge clk_in)
    begin
        if (take && code_hi == `CMD_HI_PROTECT_WRITE && protect_cmd_ok)
            protect_ram[code_lo[6:0]] <= src;
        if (take && code_hi == `CMD_HI_INSTR_PAGE_WRITE)
            instr_page[code_lo] <= src;
        if (take && code_hi == `CMD_HI_OPER_PAGE_WRITE)
            oper_page[code_lo] <= src;
    end

    // protect lookup: word = dma half + 16K span, bit 15 is the lowest 1K block
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            write_protect_out <= 1'b0;
        else
            write_protect_out <= protect_active_out &
                protect_ram[{protect_dma_in, protect_addr_in[9:4]}][4'hF - protect_addr_in[3:0]];
    end

    // shared prescaler: 10 us ticks, every tenth of them a 100 us tick
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pre_a_reg <= '0;
            pre_b_reg <= 4'h0;
            tick_a <= 1'b0;
            tick_b <= 1'b0;
        end
        else
        begin
            tick_a <= 1'b0;
            tick_b <= 1'b0;
            if (pre_a_reg == PRE_A_W'(`TIMER_A_STEP_CYC - 1))
            begin
                pre_a_reg <= '0;
                tick_a <= 1'b1;
                if (pre_b_reg == 4'(`TIMER_B_STEP_TICKS - 1))
                begin
                    pre_b_reg <= 4'h0;
                    tick_b <= 1'b1;
                end
                else
                    pre_b_reg <= pre_b_reg + 4'h1;
            end
            else
                pre_a_reg <= pre_a_reg + PRE_A_W'(1);
        end
    end

    // timer A; a free prescaler means the first step after a start is up to 10 us
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            fast_timer_count <= 16'h0000;
            timer_a_run_reg <= 1'b0;
        end
        else if (take && code == `CMD_TIMER_A_LOAD)
        begin
            fast_timer_count <= src;
            timer_a_run_reg <= 1'b1;
        end
        else
        begin
            if (take && code == `CMD_TIMER_A_START)
                timer_a_run_reg <= 1'b1;
            if (take && code == `CMD_TIMER_A_HALT)
                timer_a_run_reg <= 1'b0;
            if (timer_a_run_reg && tick_a)
                fast_timer_count <= fast_timer_count + 16'h0001;
        end
    end

    // timer B
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            slow_timer_count <= 16'h0000;
            timer_b_run_reg <= 1'b0;
        end
        else if (take && code == `CMD_TIMER_B_LOAD)
        begin
            slow_timer_count <= src;
            timer_b_run_reg <= 1'b1;
        end
        else
        begin
            if (take && code == `CMD_TIMER_B_START)
                timer_b_run_reg <= 1'b1;
            if (take && code == `CMD_TIMER_B_HALT)
                timer_b_run_reg <= 1'b0;
            if (timer_b_run_reg && tick_b)
                slow_timer_count <= slow_timer_count + 16'h0001;
        end
    end

    // go watchdog discrete
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            go_count_reg <= '0;
            go_out <= 1'b0;
        end
        else if (take && code == `CMD_GO)
        begin
            go_count_reg <= GO_W'(GO_CYCLES);
            go_out <= 1'b1;
        end
        else if (go_count_reg != '0)
        begin
            go_count_reg <= go_count_reg - GO_W'(1);
            if (go_count_reg == GO_W'(1))
                go_out <= 1'b0;
        end
    end
endmodule : io_command_unit

// >>> verilog/io_cmd_cfg.svh
// Purpose: constants of the io command unit
// Assumes: 10 MHz clock
// Notes: bit numbers count from the lsb; interrupt n sits at bit 15-n
`ifndef IO_CMD_CFG_SVH
`define IO_CMD_CFG_SVH
`define CLK_MHZ 10
`define TIMER_A_STEP_US 10
`define TIMER_B_STEP_US 100
`define TIMER_A_STEP_CYC (`TIMER_A_STEP_US * `CLK_MHZ)
`define TIMER_B_STEP_TICKS (`TIMER_B_STEP_US / `TIMER_A_STEP_US)
`define GO_TIMEOUT_MS 100
`define GO_TIMEOUT_CYC (`GO_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define CMD_MASK_WRITE 16'h2000
`define CMD_CLEAR_ALL 16'h2001
`define CMD_INT_ENABLE 16'h2002
`define CMD_INT_DISABLE 16'h2003
`define CMD_PENDING_RESET 16'h2004
`define CMD_PENDING_SET 16'h2005
`define CMD_STATUS_WRITE 16'h200E
`define CMD_MASK_READ 16'hA000
`define CMD_PENDING_READ 16'hA004
`define CMD_STATUS_READ 16'hA00E
`define CMD_FAULT_READ_CLEAR 16'hA00F
`define CMD_TERMINAL_OUT 16'h4000
`define CMD_PROTECT_ACTIVATE 16'h4003
`define CMD_DMA_ENABLE 16'h4006
`define CMD_DMA_DISABLE 16'h4007
`define CMD_TIMER_A_START 16'h4008
`define CMD_TIMER_A_HALT 16'h4009
`define CMD_TIMER_A_LOAD 16'h400A
`define CMD_GO 16'h400B
`define CMD_TIMER_B_START 16'h400C
`define CMD_TIMER_B_HALT 16'h400D
`define CMD_TIMER_B_LOAD 16'h400E
`define CMD_TIMER_A_READ 16'hC00A
`define CMD_TIMER_B_READ 16'hC00E
`define CMD_HI_PROTECT_WRITE 8'h50
`define CMD_HI_PROTECT_READ 8'hD0
`define CMD_HI_INSTR_PAGE_READ 8'hD1
`define CMD_HI_OPER_PAGE_READ 8'hD2
`define CMD_HI_INSTR_PAGE_WRITE 8'h51
`define CMD_HI_OPER_PAGE_WRITE 8'h52
`define PROTECT_WORDS 128
`define PENDING_FAULT_BIT 14
`define FAULT_ILLEGAL_IO_BIT 10
`define UNMASKABLE_DEFAULT 16'h0000
`define UNDISABLEABLE_DEFAULT 16'h0000
`endif

// >>> verilog/io_cmd_pkg.sv
// Purpose: types shared by the io command unit and its bench
// Assumes: nothing
// Notes: constants live in io_cmd_cfg.svh
package io_cmd_pkg;
    typedef struct packed {
        logic valid;
        logic [15:0] code;
        logic [15:0] src;
    } cmd_req_t;
    typedef struct packed {
        logic done;
        logic write;
        logic illegal;
        logic [15:0] data;
    } cmd_resp_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } term_byte_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TERM_HI = 2'b01,
        ST_TERM_LO = 2'b10
    } unit_state_t;
endpackage : io_cmd_pkg

// >>> tb/io_cmd_monitor.sv
// Purpose: port assertions for io_command_unit
// Assumes: one clock, sync reset
// Notes: bind below
`timescale 1ns/10ps
module io_cmd_monitor
    import io_cmd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire cmd_req_t cmd_in,
    input wire logic instr_done_in,
    input wire logic terminal_present_in,
    input wire logic cmd_ready_out,
    input wire cmd_resp_t resp_out,
    input wire term_byte_t terminal_out,
    input wire logic int_enabled_out,
    input wire logic dma_enable_out,
    input wire logic go_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire logic take = cmd_in.valid && cmd_ready_out;
    sequence co_taken;
        take && cmd_in.code == 16'h4000 && terminal_present_in;
    endsequence
    sequence hi_shown;
        terminal_out.valid && !cmd_ready_out;
    endsequence
    chk_term_hi_first: assert property (
        co_taken |=> hi_shown ##0 terminal_out.data == $past(cmd_in.src[15:8]))
        else $error("bad high byte");
    chk_term_absent_nop: assert property (
        take && cmd_in.code == 16'h4000 && !terminal_present_in
        |=> resp_out.done && !terminal_out.valid)
        else $error("absent terminal used");
    chk_read_answers: assert property (
        take && cmd_in.code inside {16'hA000, 16'hA004, 16'hA00E, 16'hA00F}
        |=> resp_out.done && resp_out.write && !resp_out.illegal)
        else $error("read unanswered");
    chk_protect_range: assert property (
        take && cmd_in.code[15:7] == 9'h0A1 |=> resp_out.done && resp_out.illegal)
        else $error("protect range");
    chk_go_rises: assert property (
        take && cmd_in.code == 16'h400B |=> go_out [*8])
        else $error("go low");
    chk_dma_follows: assert property (
        take && cmd_in.code[15:1] == 15'h2003
        |=> dma_enable_out == !$past(cmd_in.code[0]))
        else $error("dma wrong");
    chk_disable_now: assert property (
        take && cmd_in.code == 16'h2003 |-> ##3 !int_enabled_out)
        else $error("still enabled");
    chk_enable_late: assert property (
        $rose(int_enabled_out) |-> $past(instr_done_in, 2))
        else $error("early enable");
endmodule : io_cmd_monitor
bind io_command_unit io_cmd_monitor mon (.*);

// >>> tb/terminal_sink.sv
// Purpose: terminal on the far side of the byte output
// Assumes: byte taken at an edge with ready high
// Notes: ready one cycle in eight
`timescale 1ns/10ps
module terminal_sink
    import io_cmd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire term_byte_t byte_in,
    output logic ready_out
);
    logic [2:0] cnt_reg = 3'h0;
    logic [7:0] got[$];
    assign ready_out = cnt_reg == 3'h7;
    always @(posedge clk_in)
    begin
        cnt_reg <= rst_n_in ? cnt_reg + 3'h1 : 3'h0;
        if (rst_n_in && ready_out && byte_in.valid === 1'b1)
            got.push_back(byte_in.data);
    end
endmodule : terminal_sink

// >>> tb/io_command_unit_tb_top.sv
// Purpose: self-checking bench for io_command_unit
// Assumes: reads set done and write
// Notes: driver queues read notes, a watcher checks them
`timescale 1ns/10ps
module io_command_unit_tb_top;
    import io_cmd_pkg::*;
    typedef struct packed {
        logic [15:0] e;
        logic [15:0] t;
    } note_t;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    cmd_req_t req = '0;
    logic idone = 1'b0;
    logic [15:0] flt = 16'h0000;
    logic tpres = 1'b1;
    logic [9:0] paddr = 10'h000;
    logic pdma = 1'b0;
    logic trdy, rdy, ireq, ien, dma, pact, wp, go;
    cmd_resp_t resp;
    term_byte_t tout;
    logic [15:0] pend, sw, v, w, m;
    logic [15:0] bad[3] = '{16'h3000, 16'h5080, 16'hD0FF};
    logic [5:0] a;
    note_t q[$];
    note_t n;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 50292;
    initial forever #50 clk_in = ~clk_in;
    io_command_unit #(.GO_CYCLES(50)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .cmd_in(req), .instr_done_in(idone), .irq_in(16'h0000), .fault_in(flt),
        .terminal_present_in(tpres), .terminal_ready_in(trdy), .protect_addr_in(paddr),
        .protect_dma_in(pdma), .cmd_ready_out(rdy), .resp_out(resp), .terminal_out(tout),
        .int_request_out(ireq), .pending_out(pend), .status_word_out(sw),
        .int_enabled_out(ien), .dma_enable_out(dma), .protect_active_out(pact),
        .write_protect_out(wp), .go_out(go));
    terminal_sink p (.clk_in(clk_in), .rst_n_in(rst_n_in), .byte_in(tout), .ready_out(trdy));
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // idle edge between commands
    task automatic cmd(input logic [15:0] c, input logic [15:0] s);
        @(posedge clk_in);
        req <= '{1'b1, c, s};
        @(negedge clk_in);
        while (rdy !== 1'b1)
            @(negedge clk_in);
        @(posedge clk_in);
        req.valid <= 1'b0;
    endtask : cmd
    task automatic rd(input logic [15:0] c, e, t);
        q.push_back('{e, t});
        cmd(c, 16'h0000);
    endtask : rd
    always @(posedge clk_in)
    begin
        #1;
        if (resp.done === 1'b1 && resp.write === 1'b1 && q.size() > 0)
        begin
            n = q.pop_front();
            n_tests++;
            if ((resp.data ^ resp.data) !== 16'h0000 || resp.data - n.e > n.t)
            begin
                fail_count++;
                $display("unexpected at %0t: got %h want %h", $time, resp.data, n.e);
            end
        end
    end
    initial
    begin
        #(100 * 20000);
        fail_count++;
        results();
    end
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        m = $random(seed);
        v = $random(seed);
        cmd(16'h2000, m);
        rd(16'hA000, m, 16'h0000);
        cmd(16'h2005, v);
        rd(16'hA004, v, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            w = $random(seed);
            v = v & ~(16'h8000 >> w[3:0]);
            cmd(16'h2004, {12'h000, w[3:0]});
            repeat (2) @(negedge clk_in);
            chk(pend, v);
        end
        cmd(16'h2002, 16'h0000);
        @(negedge clk_in);
        chk(ien, 1'b0);
        @(posedge clk_in);
        idone <= 1'b1;
        @(posedge clk_in);
        idone <= 1'b0;
        repeat (3) @(negedge clk_in);
        chk(ien, 1'b1);
        chk(ireq, |(v & m));
        cmd(16'h2003, 16'h0000);
        repeat (3) @(negedge clk_in);
        chk(ien, 1'b0);
        chk(ireq, 1'b0);
        $display("interrupt test ends");
        w = $random(seed) | 16'h0001;
        @(posedge clk_in);
        flt <= w;
        @(posedge clk_in);
        flt <= 16'h0000;
        repeat (2) @(negedge clk_in);
        chk(pend[14], 1'b1);
        rd(16'hA00F, w, 16'h0000);
        repeat (2) @(negedge clk_in);
        chk(pend[14], 1'b0);
        rd(16'hA00F, 16'h0000, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            cmd(bad[i], 16'hFFFF);
            rd(16'hA00F, 16'h0400, 16'h0000);
        end
        rd(16'hA000, m, 16'h0000);
        @(posedge clk_in);
        flt <= 16'h0002;
        @(posedge clk_in);
        flt <= 16'h0000;
        cmd(16'h2001, 16'h0000);
        repeat (2) @(negedge clk_in);
        chk(pend, 16'h0000);
        rd(16'hA00F, 16'h0000, 16'h0000);
        cmd(16'h200E, w);
        repeat (2) @(negedge clk_in);
        chk(sw, w);
        rd(16'hA00E, w, 16'h0000);
        $display("fault test ends");
        cmd(16'h4006, 16'h0000);
        @(negedge clk_in);
        chk(dma, 1'b1);
        cmd(16'h4007, 16'h0000);
        @(negedge clk_in);
        chk(dma, 1'b0);
        cmd(16'h4003, 16'h0000);
        @(negedge clk_in);
        chk(pact, 1'b1);
        a = $random(seed);
        for (int i = 0; i < 2; i++)
        begin
            v = w ^ {16{i[0]}};
            cmd({8'h50, 1'b0, i[0], a}, v);
            rd({8'hD0, 1'b0, i[0], a}, v, 16'h0000);
            @(posedge clk_in);
            paddr <= {a, w[3:0]};
            pdma <= i[0];
            repeat (2) @(negedge clk_in);
            chk(wp, v[15 - w[3:0]]);
        end
        for (int i = 1; i < 3; i++)
            cmd({6'h14, i[1:0], 2'b00, a}, w ^ {16{i[0]}});
        for (int i = 1; i < 3; i++)
            rd({6'h34, i[1:0], 2'b00, a}, w ^ {16{i[0]}}, 16'h0000);
        $display("protect test ends");
        // a step may land before the halt
        for (int i = 0; i < 2; i++)
        begin
            cmd(16'h400A + 16'(4 * i), w);
            cmd(16'h4009 + 16'(4 * i), w);
            rd(16'hC00A + 16'(4 * i), w, 16'h0001);
            cmd(16'h4008 + 16'(4 * i), w);
            repeat (1000 + 2000 * i) @(posedge clk_in);
            cmd(16'h4009 + 16'(4 * i), w);
            repeat (300) @(posedge clk_in);
            rd(16'hC00A + 16'(4 * i), w + (i ? 16'h0002 : 16'h0009), 16'h0003);
        end
        cmd(16'h400B, 16'h0000);
        repeat (30) @(negedge clk_in);
        chk(go, 1'b1);
        cmd(16'h400B, 16'h0000);
        repeat (40) @(negedge clk_in);
        chk(go, 1'b1);
        repeat (20) @(negedge clk_in);
        chk(go, 1'b0);
        $display("timer test ends");
        cmd(16'h4000, w);
        repeat (40) @(negedge clk_in);
        chk({p.got[0], p.got[1]}, w);
        @(posedge clk_in);
        tpres <= 1'b0;
        cmd(16'h4000, m);
        repeat (9) @(negedge clk_in);
        chk(16'(p.got.size()), 16'h0002);
        $display("terminal test ends");
        results();
    end
endmodule : io_command_unit_tb_top
